// [hdl/spw_port.sv]
// serial target port turning 24-bit frames into register accesses
// How it works
// - frame starts with chip select low; input bits taken on rising clock edges.
// - eighth bit of first byte high marks a write frame.
// - eighth bit of first byte low marks a read frame.
// - second byte is the address; third byte of a write is the data.
// - on a read the third byte is shifted out from returned register data, or from the page register for address 0xFF.
// - after the 24th rising edge the write data is captured and the write held pending; address is driven at commit; enable and write flag too unless 0xFF.
// - the write is committed on the falling edge after the 24th rising edge.
// - after the 16th rising edge a read request is issued.
// - returned read data is taken before the next falling edge.
// - eight read bits leave most significant first on falling edges.
// - with the clock idle the output keeps its last bit.
// - clock rising while deselected forces the output low.
// - writing address 0xFF selects the register page.
// - the selected page stays until the page register is written again or rst reloads PAGE_RESET.
// - one register per frame; no burst and no address increment.
`timescale 1ns/1ps
module spw_port (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // serial pins
    input  wire logic       serial_clk,
    input  wire logic       chip_select_bar_pin,
    input  wire logic       serial_data_in,
    output logic            serial_data_out,
    // internal register interface
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_en,
    output logic            reg_wr,
    output logic [7:0]      reg_page,
    input  wire logic [7:0] reg_rdata
);
    // *************************************************
    // pin synchronisation and edge finding
    // *************************************************
    logic [2:0] pins_sync;
    logic       sclk_s;
    logic       desel_s;
    logic       mosi_s;
    logic       sclk_d_reg;
    logic       rise;
    logic       fall;

    spw_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({serial_clk, ~chip_select_bar_pin, serial_data_in}),
        .sync_out (pins_sync)
    );

    assign sclk_s  = pins_sync[2];
    // select travels inverted so the cleared stages read as deselected
    assign desel_s = ~pins_sync[1];
    assign mosi_s  = pins_sync[0];
    assign rise    = sclk_s & ~sclk_d_reg;
    assign fall    = ~sclk_s & sclk_d_reg;

    // *************************************************
    // frame state
    // *************************************************
    logic [4:0] cnt_reg,       cnt_next;
    logic       dir_reg,       dir_next;
    logic [7:0] addr_reg,      addr_next;
    logic [7:0] shift_reg,     shift_next;
    logic [7:0] tx_reg,        tx_next;
    logic       dout_reg,      dout_next;
    logic       wr_pend_reg,   wr_pend_next;
    logic       rd_fetch_reg,  rd_fetch_next;
    logic [7:0] page_reg,      page_next;
    logic       reg_en_reg,    reg_en_next;
    logic       reg_wr_reg,    reg_wr_next;
    logic [7:0] reg_addr_reg,  reg_addr_next;
    logic [7:0] reg_wdata_reg, reg_wdata_next;
    logic       commit;
    logic [7:0] rx_byte;

    assign rx_byte = {shift_reg[6:0], mosi_s};
    // commit on the falling edge, or on deselect if that edge never came
    assign commit  = wr_pend_reg & (desel_s | fall);

    always_comb begin
        cnt_next       = cnt_reg;
        dir_next       = dir_reg;
        addr_next      = addr_reg;
        shift_next     = shift_reg;
        tx_next        = tx_reg;
        dout_next      = dout_reg;
        wr_pend_next   = wr_pend_reg;
        rd_fetch_next  = 1'b0;
        page_next      = page_reg;
        reg_en_next    = 1'b0;
        reg_wr_next    = reg_wr_reg;
        reg_addr_next  = reg_addr_reg;
        reg_wdata_next = reg_wdata_reg;
        // read data must be valid in the same clk cycle as the read strobe
        if (rd_fetch_reg) begin
            tx_next = (reg_addr_reg == spw_pkg::PAGE_ADDR) ? page_reg : reg_rdata;
        end
        if (commit) begin
            wr_pend_next  = 1'b0;
            reg_addr_next = addr_reg;
            if (addr_reg == spw_pkg::PAGE_ADDR) begin
                page_next = reg_wdata_reg;
            end else begin
                reg_en_next = 1'b1;
                reg_wr_next = 1'b1;
            end
        end
        if (desel_s) begin
            // partial write frames are dropped: only a full frame sets wr_pend
            cnt_next = 5'h00;
            if (rise) begin
                dout_next = 1'b0;
            end
        end else begin
            if (rise && cnt_reg < spw_pkg::FRAME_END_CNT) begin
                shift_next = rx_byte;
                cnt_next   = cnt_reg + 5'h01;
                if (cnt_reg == spw_pkg::DIR_BIT_CNT) begin
                    dir_next = mosi_s;
                end
                if (cnt_reg == spw_pkg::ADDR_LAST_CNT) begin
                    addr_next = rx_byte;
                    if (!dir_reg) begin
                        reg_en_next   = 1'b1;
                        reg_wr_next   = 1'b0;
                        reg_addr_next = rx_byte;
                        rd_fetch_next = 1'b1;
                    end
                end
                if (cnt_reg == spw_pkg::DATA_LAST_CNT && dir_reg) begin
                    wr_pend_next   = 1'b1;
                    reg_wdata_next = rx_byte;
                end
            end
            // bits past the 24th are ignored: no burst
            if (fall && !dir_reg && cnt_reg >= spw_pkg::RD_FIRST_CNT
                && cnt_reg < spw_pkg::FRAME_END_CNT) begin
                dout_next = tx_reg[7];
                tx_next  = {tx_reg[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_d_reg    <= 1'b0;
            cnt_reg       <= 5'h00;
            dir_reg       <= 1'b0;
            addr_reg      <= spw_pkg::DATA_RESET;
            shift_reg     <= spw_pkg::DATA_RESET;
            tx_reg        <= spw_pkg::DATA_RESET;
            dout_reg      <= 1'b0;
            wr_pend_reg   <= 1'b0;
            rd_fetch_reg  <= 1'b0;
            page_reg      <= spw_pkg::PAGE_RESET;
            reg_en_reg    <= 1'b0;
            reg_wr_reg    <= 1'b0;
            reg_addr_reg  <= spw_pkg::DATA_RESET;
            reg_wdata_reg <= spw_pkg::DATA_RESET;
        end else begin
            sclk_d_reg    <= sclk_s;
            cnt_reg       <= cnt_next;
            dir_reg       <= dir_next;
            addr_reg      <= addr_next;
            shift_reg     <= shift_next;
            tx_reg        <= tx_next;
            dout_reg      <= dout_next;
            wr_pend_reg   <= wr_pend_next;
            rd_fetch_reg  <= rd_fetch_next;
            page_reg      <= page_next;
            reg_en_reg    <= reg_en_next;
            reg_wr_reg    <= reg_wr_next;
            reg_addr_reg  <= reg_addr_next;
            reg_wdata_reg <= reg_wdata_next;
        end
    end

    assign serial_data_out = dout_reg;
    assign reg_addr        = reg_addr_reg;
    assign reg_wdata       = reg_wdata_reg;
    assign reg_en          = reg_en_reg;
    assign reg_wr          = reg_wr_reg;
    assign reg_page        = page_reg;

    // *************************************************
    // assertions
    // *************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_dir_capture;
        rise && !desel_s && cnt_reg == 5'h07 |=> dir_reg == $past(mosi_s);
    endproperty
    a_dir_capture: assert property (p_dir_capture) else $error("direction bit not taken");

    property p_read_issue;
        rise && !desel_s && cnt_reg == 5'h0F && !dir_reg
            |=> reg_en_reg && !reg_wr_reg && reg_addr_reg == $past(rx_byte);
    endproperty
    a_read_issue: assert property (p_read_issue) else $error("read not issued");

    property p_rdata_taken;
        reg_en_reg && !reg_wr_reg && reg_addr_reg != 8'hFF |=> tx_reg == $past(reg_rdata);
    endproperty
    a_rdata_taken: assert property (p_rdata_taken) else $error("read data not taken");

    property p_first_bit;
        fall && !desel_s && !dir_reg && cnt_reg == 5'h10 |=> dout_reg == $past(tx_reg[7]);
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("first read bit wrong");

    property p_write_commit;
        fall && !desel_s && wr_pend_reg && addr_reg != 8'hFF
            |=> reg_en_reg && reg_wr_reg && reg_addr_reg == $past(addr_reg) ##1 !reg_en_reg;
    endproperty
    a_write_commit: assert property (p_write_commit) else $error("write not committed");

    property p_write_needs_frame;
        reg_en_reg && reg_wr_reg |-> $past(wr_pend_reg);
    endproperty
    a_write_needs_frame: assert property (p_write_needs_frame) else $error("write from partial frame");

    property p_idle_low;
        desel_s && rise |=> !dout_reg;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("output not low while deselected");

    property p_idle_hold;
        desel_s && !rise |=> $stable(dout_reg);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("output moved with clock idle");

    property p_page_write;
        commit && addr_reg == 8'hFF |=> page_reg == $past(reg_wdata_reg) && !reg_en_reg;
    endproperty
    a_page_write: assert property (p_page_write) else $error("page not selected");

    property p_page_kept;
        $changed(page_reg) |-> $past(wr_pend_reg);
    endproperty
    a_page_kept: assert property (p_page_kept) else $error("page changed without write");

    c_write: cover property (reg_en_reg && reg_wr_reg);
    c_read:  cover property (reg_en_reg && !reg_wr_reg ##[1:40] fall);
    c_page:  cover property (commit && addr_reg == 8'hFF);
    c_idle:  cover property (desel_s && rise);
endmodule

// [hdl/spw_pkg.sv]
// constants shared by the serial register port
package spw_pkg;
    // *************************************************
    // frame layout (bit counts after each rising edge)
    // *************************************************
    localparam int unsigned FRAME_BITS    = 24;
    localparam logic [4:0]  DIR_BIT_CNT   = 5'h07;
    localparam logic [4:0]  ADDR_LAST_CNT = 5'h0F;
    localparam logic [4:0]  DATA_LAST_CNT = 5'h17;
    localparam logic [4:0]  RD_FIRST_CNT  = 5'h10;
    localparam logic [4:0]  FRAME_END_CNT = 5'h18;
    // *************************************************
    // register map
    // *************************************************
    localparam logic [7:0]  PAGE_ADDR     = 8'hFF;
    localparam logic [7:0]  PAGE_RESET    = 8'h00;
    localparam logic [7:0]  DATA_RESET    = 8'h00;
    localparam int unsigned SYNC_STAGES   = 2;
endpackage

// [hdl/spw_sync.sv]
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module spw_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // pins and synchronised copies
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    if (WIDTH < 1) begin : g_bad_width
        $error("spw_sync width must be at least one");
    end

    // first stage is read only by the second
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule

// [testbench/spw_ctrl_model.sv]
// behavioural serial controller driving frames into the port
`timescale 1ns/1ps
module spw_ctrl_model (
    // serial pins
    output logic      serial_clk,
    output logic      chip_select_bar_pin,
    output logic      serial_data_in,
    input  wire logic serial_data_out
);
    // *************************************************
    // idle state: clock parked low, deselected
    // *************************************************
    initial begin
        serial_clk          = 1'b0;
        chip_select_bar_pin = 1'b1;
        serial_data_in      = 1'b0;
    end
    // *************************************************
    // one frame, 48 ns serial period
    // *************************************************
    task automatic frame(input logic [23:0] bits, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        chip_select_bar_pin = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            serial_data_in = (i < 24) ? bits[23-i] : i[0];
            #24 serial_clk = 1'b1;
            if (i >= 16 && i < 24) rd = {rd[6:0], serial_data_out};
            #24 serial_clk = 1'b0;
        end
        #24 chip_select_bar_pin = 1'b1;
        // released line: show the inverse so a stale sample is caught
        serial_data_in = ~serial_data_in;
        #96;
    endtask
    // one clock pulse while deselected
    task automatic toggle();
        #24 serial_clk = 1'b1;
        #24 serial_clk = 1'b0;
    endtask
endmodule

// [testbench/tb_spw_port.sv]
// self-checking bench for the serial register port
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, e); end end
module tb_spw_port;
    // *************************************************
    // signals
    // *************************************************
    logic        clk, rst, sclk, cs_n, sdi, ser_out, reg_en, reg_wr;
    logic [7:0]  reg_addr, reg_wdata, reg_page, reg_rdata, rd, a, d, pg;
    logic [7:0]  mem [256];
    logic [7:0]  shadow [256];
    logic [24:0] note_q [$];
    logic [24:0] exp_note;
    int          fail_count, compares;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    spw_port dut (.clk(clk), .rst(rst), .serial_clk(sclk), .chip_select_bar_pin(cs_n),
        .serial_data_in(sdi), .serial_data_out(ser_out), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_en(reg_en), .reg_wr(reg_wr), .reg_page(reg_page),
        .reg_rdata(reg_rdata));
    spw_ctrl_model u_ctl (.serial_clk(sclk), .chip_select_bar_pin(cs_n),
        .serial_data_in(sdi), .serial_data_out(ser_out));

    // *************************************************
    // register file behind the port, flat over pages
    // *************************************************
    initial for (int i = 0; i < 256; i++) begin
        mem[i] = 8'(i) ^ 8'h5A;
        shadow[i] = 8'(i) ^ 8'h5A;
    end
    always @(posedge clk) if (reg_en === 1'b1 && reg_wr === 1'b1) mem[reg_addr] <= #1 reg_wdata;
    assign reg_rdata = mem[reg_addr];

    // every strobe must match the oldest note
    always @(posedge clk) if (!rst && reg_en === 1'b1) begin
        if (note_q.size() == 0) begin
            `CHK(reg_en, 1'b0)
        end else begin
            exp_note = note_q.pop_front();
            `CHK({reg_wr, reg_page, reg_addr, reg_wr ? reg_wdata : 8'h00}, exp_note)
        end
    end

    // *************************************************
    // tasks
    // *************************************************
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt, input int n);
        if (n >= 24 && ad == spw_pkg::PAGE_ADDR) pg = dt;
        else if (n >= 24) begin
            note_q.push_back({1'b1, pg, ad, dt});
            shadow[ad] = dt;
        end
        @(posedge clk);
        #1 u_ctl.frame({7'($urandom), 1'b1, ad, dt}, n, rd);
    endtask
    task automatic rdchk(input logic [7:0] ad);
        note_q.push_back({1'b0, pg, ad, 8'h00});
        @(posedge clk);
        #1 u_ctl.frame({7'($urandom), 1'b0, ad, 8'h00}, 24, rd);
        `CHK(rd, (ad == spw_pkg::PAGE_ADDR) ? pg : shadow[ad])
    endtask
    task automatic wrap_up();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // *************************************************
    // tests
    // *************************************************
    initial begin
        void'($urandom(32'h1d3072af));
        rst = 1'b1;
        pg = spw_pkg::PAGE_RESET;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        #1 `CHK(reg_page, spw_pkg::PAGE_RESET)
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            a = 8'($urandom % 255);
            d = 8'($urandom);
            wr(a, d, 24);
            rdchk(a);
        end
        $display("test random access done");
        wr(8'hFF, 8'h01, 24);
        `CHK(reg_page, 8'h01)
        rdchk(8'hFF);
        wr(8'h10, 8'h5C, 24);
        rdchk(8'h10);
        wr(8'hFF, 8'h00, 24);
        $display("test page done");
        wr(8'h21, 8'hC3, 20);
        rdchk(8'h21);
        wr(8'h22, 8'h3C, 32);
        rdchk(8'h22);
        $display("test frame length done");
        wr(8'hFF, 8'h02, 24);
        `CHK(reg_page, 8'h02)
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        pg = spw_pkg::PAGE_RESET;
        repeat (3) @(posedge clk);
        #1 `CHK(reg_page, spw_pkg::PAGE_RESET)
        $display("test mid-run reset done");
        wr(8'h33, 8'hA5, 24);
        rdchk(8'h33);
        #200 `CHK(ser_out, 1'b1)
        u_ctl.toggle();
        #100 `CHK(ser_out, 1'b0)
        $display("test idle output done");
        `CHK(32'(note_q.size()), 32'h0)
        wrap_up();
    end

    // hang guard, well past the expected run length
    initial begin
        #300000;
        fail_count++;
        wrap_up();
    end
endmodule
